// *** common/cbs_pkg.sv ***
`default_nettype none

package cbs_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Widths
    localparam int unsigned CBS_DATA_W     = 18;
    localparam int unsigned CBS_ACC_W      = 48;
    localparam int unsigned CBS_CODE_W     = 7;

    ////////////////////////////////////////////////////////////////////////////
    // Cascade path
    localparam int unsigned CBS_CASC_SHIFT = 17;
    localparam int unsigned CBS_MAX_SHIFT  = 17;

    ////////////////////////////////////////////////////////////////////////////
    // Function select codes of the single-slice variant
    localparam logic [CBS_CODE_W-1:0] CBS_CODE_MUL = 7'h05;
    localparam logic [CBS_CODE_W-1:0] CBS_CODE_MAC = 7'h25;

    ////////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [CBS_DATA_W-1:0] CBS_DATA_RST = 18'h00000;
    localparam logic [CBS_ACC_W-1:0]  CBS_ACC_RST  = 48'h000000000000;
    localparam logic [CBS_CODE_W-1:0] CBS_CODE_RST = CBS_CODE_MUL;

endpackage : cbs_pkg

`default_nettype wire

// *** logic/cbs_barrel_shifter.sv ***
`timescale 1ns/1ns
`default_nettype none

// Operation
// - Rotate the 18-bit operand left by n; result is low 18 bits of slice two.
// - Bits leaving the top end come back in at the bottom end.
// - Slice one holds leading zeros, operand bits 17..1, then n trailing zeros.
// - With n zero slice one holds only leading zeros and the upper operand bits.
// - Slice one result enters slice two shifted right by seventeen.
// - With n zero the shifted cascade addend is all zero.
// - With n positive only the n top operand bits remain in the addend.
// - Slice two adds the addend to the operand shifted left by n.
// - Two-slice path takes an operand and gives a result every cycle.
// - Single slice alternates multiply 0x05 then multiply-accumulate 0x25 giving output.
module cbs_barrel_shifter (
    // Clock and reset
    input  wire logic                            clk,
    input  wire logic                            rst,
    // Two-slice request
    input  wire logic                            pipe_valid,
    input  wire logic [cbs_pkg::CBS_DATA_W-1:0]  pipe_operand,
    input  wire logic [cbs_pkg::CBS_DATA_W-1:0]  pipe_shift_pow2,
    // Two-slice answer
    output logic                                 pipe_result_valid,
    output logic      [cbs_pkg::CBS_DATA_W-1:0]  pipe_result,
    output logic                                 pipe_shift_error,
    output logic      [cbs_pkg::CBS_ACC_W-1:0]   cascade_sum_output,
    // Single-slice request
    input  wire logic                            single_valid,
    input  wire logic [cbs_pkg::CBS_DATA_W-1:0]  single_operand,
    input  wire logic [cbs_pkg::CBS_DATA_W-1:0]  single_shift_pow2,
    output logic                                 single_ready,
    // Single-slice answer
    output logic                                 single_result_valid,
    output logic      [cbs_pkg::CBS_DATA_W-1:0]  single_result,
    output logic                                 single_shift_error,
    output logic      [cbs_pkg::CBS_CODE_W-1:0]  function_select_code
);

    import cbs_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Shared arithmetic

    // Full-width product of the two multiplier inputs
    function automatic logic [CBS_ACC_W-1:0] slice_product(
        input logic [CBS_DATA_W-1:0] mul_a,
        input logic [CBS_DATA_W-1:0] mul_b
    );
        slice_product = CBS_ACC_W'(mul_a) * CBS_ACC_W'(mul_b);
    endfunction

    // Partial sum moved down by the fixed cascade shift
    function automatic logic [CBS_ACC_W-1:0] cascade_addend(
        input logic [CBS_ACC_W-1:0] addend_src
    );
        // Source is never negative, so the arithmetic shift brings in zeros
        cascade_addend = $unsigned($signed(addend_src) >>> CBS_CASC_SHIFT);
    endfunction

    // One slice step: multiply, or multiply plus the seventeen-bit-shifted sum
    function automatic logic [CBS_ACC_W-1:0] slice_op(
        input logic [CBS_CODE_W-1:0] code,
        input logic [CBS_DATA_W-1:0] mul_a,
        input logic [CBS_DATA_W-1:0] mul_b,
        input logic [CBS_ACC_W-1:0]  addend_src
    );
        if (code == CBS_CODE_MAC) begin
            slice_op = slice_product(mul_a, mul_b) + cascade_addend(addend_src);
        end else begin
            slice_op = slice_product(mul_a, mul_b);
        end
    endfunction

    // Top seventeen operand bits, zero extended, as slice one's multiplicand
    function automatic logic [CBS_DATA_W-1:0] upper_bits(
        input logic [CBS_DATA_W-1:0] operand
    );
        upper_bits = {1'b0, operand[CBS_DATA_W-1:1]};
    endfunction

    // The rotated word sits in the low bits of a slice sum
    function automatic logic [CBS_DATA_W-1:0] low_word(
        input logic [CBS_ACC_W-1:0] sum
    );
        low_word = sum[CBS_DATA_W-1:0];
    endfunction

    // A legal shift value has exactly one bit set, which bounds n to 0..17
    // An illegal one is still computed; only the error flag marks the word
    function automatic logic shift_is_illegal(
        input logic [CBS_DATA_W-1:0] pow2
    );
        logic [CBS_DATA_W-1:0] less_one;
        less_one = CBS_DATA_W'(pow2 - 18'h00001);
        shift_is_illegal = (pow2 == CBS_DATA_RST) ||
                           ((pow2 & less_one) != CBS_DATA_RST);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Two-slice pipeline

    logic                  s0_valid;
    logic [CBS_DATA_W-1:0] s0_operand;
    logic [CBS_DATA_W-1:0] s0_pow2;
    logic                  s0_err;
    logic                  s1_valid;
    logic [CBS_DATA_W-1:0] s1_operand;
    logic [CBS_DATA_W-1:0] s1_pow2;
    logic                  s1_err;

    logic                  next_s0_valid;
    logic [CBS_DATA_W-1:0] next_s0_operand;
    logic [CBS_DATA_W-1:0] next_s0_pow2;
    logic                  next_s0_err;
    logic                  next_s1_valid;
    logic [CBS_DATA_W-1:0] next_s1_operand;
    logic [CBS_DATA_W-1:0] next_s1_pow2;
    logic                  next_s1_err;
    logic [CBS_ACC_W-1:0]  next_cascade;
    logic [CBS_ACC_W-1:0]  slice2_sum;
    logic                  next_pipe_result_valid;
    logic [CBS_DATA_W-1:0] next_pipe_result;
    logic                  next_pipe_shift_error;

    // Operand and shift are delayed beside slice one so both reach slice two together
    always_comb begin
        next_s0_valid   = pipe_valid;
        next_s0_operand = pipe_operand;
        next_s0_pow2    = pipe_shift_pow2;
        next_s0_err     = pipe_valid && shift_is_illegal(pipe_shift_pow2);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s0_valid   <= 1'b0;
            s0_operand <= CBS_DATA_RST;
            s0_pow2    <= CBS_DATA_RST;
            s0_err     <= 1'b0;
        end else begin
            s0_valid   <= next_s0_valid;
            s0_operand <= next_s0_operand;
            s0_pow2    <= next_s0_pow2;
            s0_err     <= next_s0_err;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Slice one

    // The delayed operand travels beside the cascade sum
    always_comb begin
        next_s1_valid   = s0_valid;
        next_s1_operand = s0_operand;
        next_s1_pow2    = s0_pow2;
        next_s1_err     = s0_err;
        // Zero-padded shifted copy; with n zero there are no trailing zeros
        next_cascade    = slice_op(CBS_CODE_MUL, upper_bits(s0_operand), s0_pow2,
                                   CBS_ACC_RST);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s1_valid           <= 1'b0;
            s1_operand         <= CBS_DATA_RST;
            s1_pow2            <= CBS_DATA_RST;
            s1_err             <= 1'b0;
            cascade_sum_output <= CBS_ACC_RST;
        end else begin
            s1_valid           <= next_s1_valid;
            s1_operand         <= next_s1_operand;
            s1_pow2            <= next_s1_pow2;
            s1_err             <= next_s1_err;
            cascade_sum_output <= next_cascade;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Slice two

    // The wrapped top bits fill the zeros that the left shift leaves
    always_comb begin
        // Addend is zero for n zero, else the n top operand bits
        slice2_sum             = slice_op(CBS_CODE_MAC, s1_operand, s1_pow2,
                                          cascade_sum_output);
        next_pipe_result_valid = s1_valid;
        next_pipe_result       = low_word(slice2_sum);
        next_pipe_shift_error  = s1_err;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pipe_result_valid <= 1'b0;
            pipe_result       <= CBS_DATA_RST;
            pipe_shift_error  <= 1'b0;
        end else begin
            pipe_result_valid <= next_pipe_result_valid;
            pipe_result       <= next_pipe_result;
            pipe_shift_error  <= next_pipe_shift_error;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Single-slice variant

    typedef enum logic {
        CBS_PHASE_MUL,
        CBS_PHASE_MAC
    } cbs_phase_type;

    cbs_phase_type         ss_phase;
    logic [CBS_DATA_W-1:0] ss_operand;
    logic [CBS_DATA_W-1:0] ss_pow2;
    logic                  ss_err;
    logic [CBS_ACC_W-1:0]  ss_sum;

    cbs_phase_type         next_ss_phase;
    logic [CBS_DATA_W-1:0] next_ss_operand;
    logic [CBS_DATA_W-1:0] next_ss_pow2;
    logic                  next_ss_err;
    logic [CBS_ACC_W-1:0]  next_ss_sum;
    logic                  next_single_ready;
    logic                  next_single_result_valid;
    logic [CBS_DATA_W-1:0] next_single_result;
    logic                  next_single_shift_error;
    logic [CBS_CODE_W-1:0] next_function_select_code;

    // Operand is held inside, so the caller presents it once; half the throughput
    always_comb begin
        next_ss_phase             = ss_phase;
        next_ss_operand           = ss_operand;
        next_ss_pow2              = ss_pow2;
        next_ss_err               = ss_err;
        next_ss_sum               = ss_sum;
        next_function_select_code = function_select_code;
        case (ss_phase)
            CBS_PHASE_MUL: begin
                if (single_valid) begin
                    next_ss_operand           = single_operand;
                    next_ss_pow2              = single_shift_pow2;
                    next_ss_err               = shift_is_illegal(single_shift_pow2);
                    next_ss_sum               = slice_op(CBS_CODE_MUL,
                                                         upper_bits(single_operand),
                                                         single_shift_pow2,
                                                         CBS_ACC_RST);
                    next_function_select_code = CBS_CODE_MUL;
                    next_ss_phase             = CBS_PHASE_MAC;
                end
            end
            CBS_PHASE_MAC: begin
                next_ss_sum               = slice_op(CBS_CODE_MAC, ss_operand, ss_pow2,
                                                     ss_sum);
                next_function_select_code = CBS_CODE_MAC;
                next_ss_phase             = CBS_PHASE_MUL;
            end
            default: begin
                next_ss_phase = CBS_PHASE_MUL;
            end
        endcase
        next_single_ready = (next_ss_phase == CBS_PHASE_MUL);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ss_phase             <= CBS_PHASE_MUL;
            ss_operand           <= CBS_DATA_RST;
            ss_pow2              <= CBS_DATA_RST;
            ss_err               <= 1'b0;
            ss_sum               <= CBS_ACC_RST;
            single_ready         <= 1'b1;
            function_select_code <= CBS_CODE_RST;
        end else begin
            ss_phase             <= next_ss_phase;
            ss_operand           <= next_ss_operand;
            ss_pow2              <= next_ss_pow2;
            ss_err               <= next_ss_err;
            ss_sum               <= next_ss_sum;
            single_ready         <= next_single_ready;
            function_select_code <= next_function_select_code;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Single-slice answer

    // Result and error hold between answers, so a slow reader can still take them
    always_comb begin
        next_single_result_valid = 1'b0;
        next_single_result       = single_result;
        next_single_shift_error  = single_shift_error;
        if (ss_phase == CBS_PHASE_MAC) begin
            next_single_result_valid = 1'b1;
            next_single_result       = low_word(next_ss_sum);
            next_single_shift_error  = ss_err;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            single_result_valid <= 1'b0;
            single_result       <= CBS_DATA_RST;
            single_shift_error  <= 1'b0;
        end else begin
            single_result_valid <= next_single_result_valid;
            single_result       <= next_single_result;
            single_shift_error  <= next_single_shift_error;
        end
    end

endmodule // cbs_barrel_shifter

`default_nettype wire

// *** testbench/cbs_barrel_shifter_chk.sv ***
`timescale 1ns/1ns
`default_nettype none

module cbs_chk
    import cbs_pkg::*;
(
    // Clock and reset
    input wire logic        clk,
    input wire logic        rst,
    // Two-slice path
    input wire logic        pipe_valid,
    input wire logic [17:0] pipe_operand,
    input wire logic [17:0] pipe_shift_pow2,
    input wire logic        pipe_result_valid,
    input wire logic [17:0] pipe_result,
    input wire logic [47:0] cascade_sum_output,
    // Single-slice path
    input wire logic        single_valid,
    input wire logic [17:0] single_operand,
    input wire logic [17:0] single_shift_pow2,
    input wire logic        single_ready,
    input wire logic        single_result_valid,
    input wire logic [17:0] single_result,
    input wire logic [6:0]  function_select_code
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // Product with the power of two; the wrapped bits land above bit 17
    function automatic logic [17:0] rot(logic [17:0] x, logic [17:0] p);
        return 18'((36'(x) * 36'(p)) | ((36'(x) * 36'(p)) >> 18));
    endfunction

    ////////////////////////////////////////////////////////////////////////
    a_pipe_latency: assert property (
        pipe_valid |-> ##3 pipe_result_valid) else $error("pipe result late");
    a_pipe_spurious: assert property (
        pipe_result_valid |-> $past(pipe_valid, 3)) else $error("pipe result unasked");
    a_pipe_rotate: assert property (
        pipe_valid && $onehot(pipe_shift_pow2) |-> ##3
        pipe_result == rot($past(pipe_operand, 3), $past(pipe_shift_pow2, 3)))
        else $error("pipe rot");
    a_addend_top: assert property (
        pipe_valid && $onehot(pipe_shift_pow2) |-> ##2
        (cascade_sum_output >> 17) < 48'($past(pipe_shift_pow2, 2))) else $error("addend wide");
    a_addend_wrap: assert property (
        pipe_valid && $onehot(pipe_shift_pow2) |-> ##3 (pipe_result & 18'($past(pipe_shift_pow2, 3)
        - 1)) == 18'($past(cascade_sum_output, 1) >> 17)) else $error("wrapped bits");
    a_single_ready: assert property (
        single_valid && single_ready |=> !single_ready ##1 (single_ready && single_result_valid))
        else $error("single handshake");
    a_single_codes: assert property (
        single_valid && single_ready |=> function_select_code == CBS_CODE_MUL
        ##1 function_select_code == CBS_CODE_MAC) else $error("code order");
    a_single_rotate: assert property (
        single_valid && single_ready && $onehot(single_shift_pow2) |-> ##2
        single_result == rot($past(single_operand, 2), $past(single_shift_pow2, 2)))
        else $error("single rot");

    c_stream: cover property (pipe_result_valid [*4]);
    c_single: cover property (single_result_valid ##2 single_result_valid);
    c_error: cover property (pipe_valid && !$onehot(pipe_shift_pow2));
endmodule // cbs_chk

bind cbs_barrel_shifter cbs_chk u_chk (.*);

`default_nettype wire

// *** testbench/cbs_src.sv ***
`timescale 1ns/1ns
`default_nettype none

module cbs_src (
    // Clock
    input  wire logic        clk,
    // Scenario request
    input  wire logic        go,
    input  wire logic        bad,
    input  wire logic [4:0]  n,
    input  wire logic [17:0] op,
    // Toward the shifter
    output var logic         valid = 1'b0,
    output var logic [17:0]  operand = 18'h00000,
    output var logic [17:0]  pow2 = 18'h00000
);
    // Idle lines toggle so a stale word can never pass for a fresh one
    always @(negedge clk) begin
        valid   <= go;
        operand <= go ? op : ~operand;
        pow2    <= !go ? ~pow2 : bad ? 18'(n) : 18'h00001 << n;
    end
endmodule // cbs_src

`default_nettype wire

// *** testbench/tb.sv ***
`timescale 1ns/1ns
`default_nettype none

module tb;
    import cbs_pkg::*;
    // Bench controls
    logic        clk = 1'b0, rst = 1'b1, p_go = 1'b0, p_bad = 1'b0, s_go = 1'b0, s_bad = 1'b0;
    logic [4:0]  p_n = 5'h00, s_n = 5'h00;
    logic [17:0] p_op = 18'h00000, s_op = 18'h00000;
    int          fails = 0, checks = 0, cyc = 0;
    // Shifter ports
    logic        pipe_valid, pipe_result_valid, pipe_shift_error, single_valid, single_ready;
    logic        single_result_valid, single_shift_error;
    logic [17:0] pipe_operand, pipe_shift_pow2, pipe_result, single_operand, single_shift_pow2;
    logic [17:0] single_result;
    logic [47:0] cascade_sum_output;
    logic [6:0]  function_select_code;
    wire  [8:0]  s_stat = {single_ready, single_result_valid, function_select_code};

    cbs_barrel_shifter dut (.*);
    cbs_src src_p (.clk, .go(p_go), .bad(p_bad), .n(p_n), .op(p_op), .valid(pipe_valid),
                   .operand(pipe_operand), .pow2(pipe_shift_pow2));
    cbs_src src_s (.clk, .go(s_go), .bad(s_bad), .n(s_n), .op(s_op), .valid(single_valid),
                   .operand(single_operand), .pow2(single_shift_pow2));

    ////////////////////////////////////////////////////////////////////////
    initial forever #25 clk = ~clk;
    // The run needs about fifty cycles; the ceiling only cuts a hang
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            fails++;
            give_verdict();
        end
    end

    task automatic give_verdict();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(string what, logic [47:0] seen, logic [47:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    function automatic logic [17:0] opv(int j);
        return 18'h2b4c7 ^ 18'(j * 5003);
    endfunction

    function automatic logic [17:0] rotl(logic [17:0] x, int n);
        return (x << n) | (x >> (18 - n));
    endfunction

    task automatic t_reset();
        chk("reset stat", {s_stat, pipe_result_valid}, {2'b10, CBS_CODE_RST, 1'b0});
        chk("reset results", {pipe_result, single_result}, 36'h000000000);
        chk("reset cascade", cascade_sum_output, CBS_ACC_RST);
        $display("test reset done");
    endtask

    // Request i is taken one edge after it is set; cascade shows two edges on, result three
    task automatic t_pipe(string name, int num, logic bad);
        for (int i = 0; i < num + 3; i++) begin
            @(posedge clk);
            #1;
            chk("pipe valid", pipe_result_valid, i >= 3);
            if (i >= 3) chk("pipe error", pipe_shift_error, bad);
            if (i >= 3 && !bad)
                chk("pipe result", pipe_result, rotl(opv(i - 3), i - 3));
            if (i >= 2 && i < num + 2 && !bad)
                chk("cascade", cascade_sum_output, 48'(opv(i - 2) >> 1) << (i - 2));
            p_go = i < num;
            p_bad = bad;
            p_op = opv(i);
            p_n = bad ? 5'(3 * i) : 5'(i);
        end
        $display("test %s done", name);
    endtask

    // Valid stays up through the busy cycle, so the ignored request is exercised too
    task automatic t_single();
        int sn [5] = '{0, 1, 9, 17, 3};
        for (int m = 0; m < 5; m++) begin
            s_go = 1'b1;
            s_bad = m == 4;
            s_op = opv(m + 7);
            s_n = 5'(sn[m]);
            @(posedge clk);
            #1;
            chk("stage one", s_stat, {2'b00, CBS_CODE_MUL});
            @(posedge clk);
            #1;
            chk("stage two", s_stat, {2'b11, CBS_CODE_MAC});
            chk("single error", single_shift_error, s_bad);
            if (m < 4) chk("single result", single_result, rotl(s_op, sn[m]));
        end
        s_go = 1'b0;
        $display("test single done");
    endtask

    initial begin
        repeat (16) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        @(posedge clk);
        #1;
        t_reset();
        t_pipe("stream", 18, 1'b0);
        t_pipe("bad shift", 2, 1'b1);
        t_single();
        give_verdict();
    end
endmodule // tb

`default_nettype wire
